// *** logic/ddr_pins_pkg.sv ***
// Shared constants and state type for the SDRAM column and data pin block
package ddr_pins_pkg;
   localparam int DATA_W      = 16;
   localparam int LANES       = 2;
   localparam int LANE_W      = 8;
   localparam int BANK_W      = 2;
   localparam int BANKS       = 4;
   localparam int ADDR_W      = 13;
   localparam int COL_W       = 9;
   localparam int ALL_BANKS_BIT = 10;
   localparam int BURST_LEN   = 4;
   localparam int BEAT_W      = 2;
   localparam int READ_LATENCY = 2;
   localparam int FIFO_DEPTH  = 32;
   localparam int MEM_AW      = BANK_W + COL_W;
   localparam int MEM_WORDS   = 2048;
   localparam int SYNC_W      = 40;
   localparam logic [BANKS-1:0]  BANKS_RESET = 4'h0;
   localparam logic [DATA_W-1:0] DATA_RESET  = 16'h0000;
   typedef enum {
      ST_IDLE,
      ST_RD_WAIT,
      ST_RD_PRE,
      ST_RD_BURST,
      ST_RD_POST,
      ST_WR_BURST
   } link_state_e;
endpackage

// *** logic/sync2.sv ***
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk) begin
      if (rst) begin
         stage1   <= '0;
         sync_out <= '0;
      end else if (ce) begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// *** logic/word_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic             push;
   logic             pop;

   assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data  = store[rd_ptr[AW-1:0]];
   assign push      = ce && in_valid && in_ready;
   assign pop       = ce && out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         store[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule

// *** logic/ddr_column_data_pins.sv ***
// Device-side command decode, byte strobes, masking and double-rate data bus
//
// Function
// - Commands latched only on system clock rising edges
// - CS low, RAS high, CAS low starts column access to an open bank when idle
// - Write-select high reads, low writes
// - Write-select also splits activate from precharge
// - Strobes bidirectional: device reads, controller writes
// - Read strobe edges aligned with output data
// - Lower strobe times bits 0-7, upper 8-15
// - Masked write byte keeps old stored contents
// - Lower mask gates bits 0-7, upper 8-15
// - One word per rising and falling strobe edge
// - Chip select high ignores every command
// - Row command: activate or precharge the bank; precharge with address bit 10 set closes all banks
`timescale 1ns/100ps
module ddr_column_data_pins (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        system_clock,
   input  wire logic        chip_select_n,
   input  wire logic        row_strobe_n,
   input  wire logic        column_strobe_n,
   input  wire logic        write_select_n,
   input  wire logic [1:0]  bank_select,
   input  wire logic [12:0] address,
   input  wire logic        lower_byte_strobe_in,
   output logic             lower_byte_strobe_out,
   output logic             lower_byte_strobe_oe,
   input  wire logic        upper_byte_strobe_in,
   output logic             upper_byte_strobe_out,
   output logic             upper_byte_strobe_oe,
   input  wire logic        lower_byte_mask,
   input  wire logic        upper_byte_mask,
   input  wire logic [15:0] data_lines_in,
   output logic      [15:0] data_lines_out,
   output logic             data_lines_oe,
   output logic      [3:0]  bank_open,
   output logic             read_active,
   output logic             write_active
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation
   // One shared synchroniser keeps data, mask and strobe aligned
   logic [ddr_pins_pkg::SYNC_W-1:0] pins_raw;
   logic [ddr_pins_pkg::SYNC_W-1:0] pins_s;

   assign pins_raw = {system_clock, chip_select_n, row_strobe_n, column_strobe_n,
                      write_select_n, bank_select, address,
                      upper_byte_strobe_in, lower_byte_strobe_in,
                      upper_byte_mask, lower_byte_mask, data_lines_in};

   sync2 #(
      .WIDTH    (ddr_pins_pkg::SYNC_W)
   ) pin_sync (
      .clk      (clk),
      .rst      (rst),
      .ce       (ce),
      .async_in (pins_raw),
      .sync_out (pins_s)
   );

   logic        sck_s;
   logic        cs_n_s;
   logic        ras_n_s;
   logic        cas_n_s;
   logic        we_n_s;
   logic [1:0]  bank_s;
   logic [12:0] addr_s;
   logic [1:0]  strobe_s;
   logic [1:0]  mask_s;
   logic [15:0] data_s;

   assign sck_s    = pins_s[39];
   assign cs_n_s   = pins_s[38];
   assign ras_n_s  = pins_s[37];
   assign cas_n_s  = pins_s[36];
   assign we_n_s   = pins_s[35];
   assign bank_s   = pins_s[34:33];
   assign addr_s   = pins_s[32:20];
   assign strobe_s = pins_s[19:18];
   assign mask_s   = pins_s[17:16];
   assign data_s   = pins_s[15:0];

   ////////////////////////////////////////////////////////////////////////////
   // System clock edge detection and command decode
   logic sck_prev;
   logic sck_rise;
   logic sck_edge;

   always_ff @(posedge clk) begin
      if (rst) begin
         sck_prev <= 1'b0;
      end else if (ce) begin
         sck_prev <= sck_s;
      end
   end

   assign sck_rise = sck_s && !sck_prev;
   assign sck_edge = sck_s != sck_prev;

   logic cmd_taken;
   logic cmd_activate;
   logic cmd_precharge;
   logic cmd_read;
   logic cmd_write;
   logic col_bank_open;

   assign cmd_taken     = sck_rise && !cs_n_s;
   assign cmd_activate  = cmd_taken && !ras_n_s && cas_n_s && we_n_s;
   assign cmd_precharge = cmd_taken && !ras_n_s && cas_n_s && !we_n_s;
   assign col_bank_open = bank_open[bank_s];
   assign cmd_read      = cmd_taken && ras_n_s && !cas_n_s && we_n_s
                          && col_bank_open;
   assign cmd_write     = cmd_taken && ras_n_s && !cas_n_s && !we_n_s
                          && col_bank_open;

   always_ff @(posedge clk) begin
      if (rst) begin
         bank_open <= ddr_pins_pkg::BANKS_RESET;
      end else if (ce) begin
         if (cmd_activate) begin
            bank_open[bank_s] <= 1'b1;
         end else if (cmd_precharge) begin
            if (addr_s[ddr_pins_pkg::ALL_BANKS_BIT]) begin
               bank_open <= ddr_pins_pkg::BANKS_RESET;
            end else begin
               bank_open[bank_s] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link state machine
   ddr_pins_pkg::link_state_e state;
   logic             start_read;
   logic             start_write;
   logic [1:0]       lane_done;
   logic [ddr_pins_pkg::MEM_AW-1:0] burst_base;
   logic [1:0]       lat_cnt;
   logic [ddr_pins_pkg::BEAT_W:0] rd_beat;
   logic             rd_pop_slot;
   logic             fifo_out_valid;
   logic [15:0]      fifo_out_data;
   logic             drive;
   logic             strobe_level;

   // Column commands that arrive during a burst are dropped; row commands never are
   assign start_read  = (state == ddr_pins_pkg::ST_IDLE) && cmd_read;
   assign start_write = (state == ddr_pins_pkg::ST_IDLE) && cmd_write;
   assign read_active  = drive;
   assign write_active = state == ddr_pins_pkg::ST_WR_BURST;
   assign rd_pop_slot = sck_edge && ((state == ddr_pins_pkg::ST_RD_PRE)
                        || ((state == ddr_pins_pkg::ST_RD_BURST)
                        && (rd_beat != ddr_pins_pkg::BURST_LEN[ddr_pins_pkg::BEAT_W:0])));

   always_ff @(posedge clk) begin
      if (rst) begin
         burst_base <= '0;
      end else if (ce && (start_read || start_write)) begin
         burst_base <= {bank_s, addr_s[ddr_pins_pkg::COL_W-1:0]};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state   <= ddr_pins_pkg::ST_IDLE;
         lat_cnt <= '0;
         rd_beat <= '0;
      end else if (ce) begin
         case (state)
            ddr_pins_pkg::ST_IDLE: begin
               lat_cnt <= '0;
               rd_beat <= '0;
               if (start_read) begin
                  state <= ddr_pins_pkg::ST_RD_WAIT;
               end else if (start_write) begin
                  state <= ddr_pins_pkg::ST_WR_BURST;
               end
            end
            ddr_pins_pkg::ST_RD_WAIT: begin
               if (sck_rise) begin
                  if (lat_cnt == 2'(ddr_pins_pkg::READ_LATENCY - 1)) begin
                     state <= ddr_pins_pkg::ST_RD_PRE;
                  end else begin
                     lat_cnt <= lat_cnt + 2'h1;
                  end
               end
            end
            ddr_pins_pkg::ST_RD_PRE: begin
               if (sck_edge) begin
                  state   <= ddr_pins_pkg::ST_RD_BURST;
                  rd_beat <= 3'h1;
               end
            end
            ddr_pins_pkg::ST_RD_BURST: begin
               if (sck_edge) begin
                  if (rd_pop_slot) begin
                     rd_beat <= rd_beat + 3'h1;
                  end else begin
                     state <= ddr_pins_pkg::ST_RD_POST;
                  end
               end
            end
            ddr_pins_pkg::ST_RD_POST: begin
               if (sck_edge) begin
                  state <= ddr_pins_pkg::ST_IDLE;
               end
            end
            ddr_pins_pkg::ST_WR_BURST: begin
               if (&lane_done) begin
                  state <= ddr_pins_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= ddr_pins_pkg::ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read pin drive
   // Strobe toggles in the same cycle the data word changes, so every strobe
   // edge marks a data transition; preamble and postamble hold it low.
   always_ff @(posedge clk) begin
      if (rst) begin
         drive          <= 1'b0;
         strobe_level   <= 1'b0;
         data_lines_out <= ddr_pins_pkg::DATA_RESET;
      end else if (ce) begin
         if (state == ddr_pins_pkg::ST_RD_WAIT && sck_rise
             && lat_cnt == 2'(ddr_pins_pkg::READ_LATENCY - 1)) begin
            drive        <= 1'b1;
            strobe_level <= 1'b0;
         end else if (state == ddr_pins_pkg::ST_RD_POST && sck_edge) begin
            drive        <= 1'b0;
         end
         if (rd_pop_slot) begin
            strobe_level <= !strobe_level;
            if (fifo_out_valid) begin
               data_lines_out <= fifo_out_data;
            end
         end
      end
   end

   assign lower_byte_strobe_out = strobe_level;
   assign upper_byte_strobe_out = strobe_level;
   assign lower_byte_strobe_oe  = drive;
   assign upper_byte_strobe_oe  = drive;
   assign data_lines_oe         = drive;

   ////////////////////////////////////////////////////////////////////////////
   // Byte lanes: write capture per own strobe, masked byte storage
   logic [ddr_pins_pkg::MEM_AW-1:0] fetch_addr;
   logic [15:0]                     fetch_word;

   for (genvar i = 0; i < ddr_pins_pkg::LANES; i++) begin : g_lane
      logic [7:0]                    lane_mem [0:ddr_pins_pkg::MEM_WORDS-1];
      logic [ddr_pins_pkg::BEAT_W:0] cnt;
      logic                          strobe_prev;
      logic                          beat;
      logic [ddr_pins_pkg::MEM_AW-1:0] wr_addr;

      // Controller must keep the strobe low through the write preamble
      assign beat = write_active && (strobe_s[i] != strobe_prev)
                    && (cnt != ddr_pins_pkg::BURST_LEN[ddr_pins_pkg::BEAT_W:0]);
      // Sequential order, wrapping inside the burst-aligned block
      assign wr_addr = {burst_base[ddr_pins_pkg::MEM_AW-1:ddr_pins_pkg::BEAT_W],
                        burst_base[ddr_pins_pkg::BEAT_W-1:0] + cnt[ddr_pins_pkg::BEAT_W-1:0]};
      assign lane_done[i] = cnt == ddr_pins_pkg::BURST_LEN[ddr_pins_pkg::BEAT_W:0];
      assign fetch_word[i*8 +: 8] = lane_mem[fetch_addr];

      always_ff @(posedge clk) begin
         if (rst) begin
            strobe_prev <= 1'b0;
            cnt         <= '0;
         end else if (ce) begin
            strobe_prev <= strobe_s[i];
            if (start_write) begin
               cnt <= '0;
            end else if (beat) begin
               cnt <= cnt + 3'h1;
            end
         end
      end

      always_ff @(posedge clk) begin
         if (ce && beat && !mask_s[i]) begin
            lane_mem[wr_addr] <= data_s[i*8 +: 8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read fetch into the FIFO; fetch stalls while the FIFO is full
   logic                          fetch_busy;
   logic [ddr_pins_pkg::BEAT_W-1:0] fetch_cnt;
   logic                          fifo_in_ready;

   assign fetch_addr = {burst_base[ddr_pins_pkg::MEM_AW-1:ddr_pins_pkg::BEAT_W],
                        burst_base[ddr_pins_pkg::BEAT_W-1:0] + fetch_cnt};

   always_ff @(posedge clk) begin
      if (rst) begin
         fetch_busy <= 1'b0;
         fetch_cnt  <= '0;
      end else if (ce) begin
         if (start_read) begin
            fetch_busy <= 1'b1;
            fetch_cnt  <= '0;
         end else if (fetch_busy && fifo_in_ready) begin
            fetch_cnt <= fetch_cnt + 2'h1;
            if (fetch_cnt == 2'(ddr_pins_pkg::BURST_LEN - 1)) begin
               fetch_busy <= 1'b0;
            end
         end
      end
   end

   word_fifo #(
      .WIDTH     (ddr_pins_pkg::DATA_W),
      .DEPTH     (ddr_pins_pkg::FIFO_DEPTH)
   ) read_fifo (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .in_valid  (fetch_busy),
      .in_ready  (fifo_in_ready),
      .in_data   (fetch_word),
      .out_valid (fifo_out_valid),
      .out_ready (rd_pop_slot),
      .out_data  (fifo_out_data)
   );
endmodule

// *** logic/unused_placeholder_removed.sv ***
// No design unit

// *** testbench/ddr_pins_sva.sv ***
// Checks on command decode and read drive
`timescale 1ns/100ps
module ddr_pins_sva (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       system_clock,
   input wire logic       chip_select_n,
   input wire logic       row_strobe_n,
   input wire logic       column_strobe_n,
   input wire logic       write_select_n,
   input wire logic       lower_byte_strobe_out,
   input wire logic       lower_byte_strobe_oe,
   input wire logic       upper_byte_strobe_out,
   input wire logic       upper_byte_strobe_oe,
   input wire logic       data_lines_oe,
   input wire logic [3:0] bank_open,
   input wire logic       read_active,
   input wire logic       write_active
);
   logic       ck_d;
   logic       ls_d;
   logic [3:0] cmd_at_rise;
   logic [3:0] since_rise;
   logic [5:0] oe_len;
   logic [2:0] toggles;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   // Raw pins at the link clock rise
   always_ff @(posedge clk) begin
      ck_d <= system_clock;
      if (system_clock && !ck_d) begin
         cmd_at_rise <= {chip_select_n, row_strobe_n, column_strobe_n, write_select_n};
      end
   end
   always_ff @(posedge clk) begin
      if (rst) since_rise <= 4'hF;
      else if (system_clock && !ck_d) since_rise <= 4'h0;
      else if (since_rise != 4'hF) since_rise <= since_rise + 4'h1;
   end
   always_ff @(posedge clk) begin
      ls_d <= lower_byte_strobe_out;
      oe_len <= data_lines_oe ? oe_len + 6'h01 : 6'h00;
      if (!data_lines_oe) toggles <= 3'h0;
      else if (lower_byte_strobe_out != ls_d) toggles <= toggles + 3'h1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Sync plus decode lag
   sequence s_taken; since_rise inside {[1:5]}; endsequence
   sequence s_preamble; !lower_byte_strobe_out [*3]; endsequence
   property p_window; $changed(bank_open) |-> s_taken; endproperty
   property p_cs; $changed(bank_open) |-> cmd_at_rise[3:1] == 3'h1; endproperty
   property p_open; |(bank_open & ~$past(bank_open)) |-> cmd_at_rise[0]; endproperty
   property p_close; |(~bank_open & $past(bank_open)) |-> !cmd_at_rise[0]; endproperty
   property p_wr; $rose(write_active) |-> s_taken ##0 cmd_at_rise == 4'h4; endproperty
   property p_en;
      data_lines_oe == lower_byte_strobe_oe && data_lines_oe == upper_byte_strobe_oe
         && read_active == data_lines_oe;
   endproperty
   property p_dir; write_active |-> !data_lines_oe; endproperty
   property p_pair; lower_byte_strobe_out == upper_byte_strobe_out; endproperty
   property p_pre; $rose(data_lines_oe) |-> s_preamble; endproperty
   property p_idle; !data_lines_oe |-> !lower_byte_strobe_out; endproperty
   property p_beats; $fell(data_lines_oe) |-> toggles == 3'h4; endproperty
   property p_len; $fell(data_lines_oe) |-> oe_len inside {[22:26]}; endproperty
   a_window: assert property (p_window) else $error("bank off rise");
   a_cs: assert property (p_cs) else $error("stray bank change");
   a_open: assert property (p_open) else $error("bad bank open");
   a_close: assert property (p_close) else $error("bad bank close");
   a_wr: assert property (p_wr) else $error("bad write start");
   a_en: assert property (p_en) else $error("enables differ");
   a_dir: assert property (p_dir) else $error("drive in write");
   a_pair: assert property (p_pair) else $error("strobes differ");
   a_pre: assert property (p_pre) else $error("bad preamble");
   a_idle: assert property (p_idle) else $error("strobe high idle");
   a_beats: assert property (p_beats) else $error("bad edge count");
   a_len: assert property (p_len) else $error("bad drive length");
endmodule

bind ddr_column_data_pins ddr_pins_sva u_ddr_pins_sva (
   .clk(clk), .rst(rst), .system_clock(system_clock), .chip_select_n(chip_select_n),
   .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
   .write_select_n(write_select_n), .lower_byte_strobe_out(lower_byte_strobe_out),
   .lower_byte_strobe_oe(lower_byte_strobe_oe), .upper_byte_strobe_out(upper_byte_strobe_out),
   .upper_byte_strobe_oe(upper_byte_strobe_oe), .data_lines_oe(data_lines_oe),
   .bank_open(bank_open), .read_active(read_active), .write_active(write_active));

// *** testbench/ddr_ctrl_model.sv ***
// Controller model: link clock, commands, writes, read capture
`timescale 1ns/100ps
module ddr_ctrl_model (
   input  wire logic        clk,
   output logic             system_clock,
   output logic             chip_select_n,
   output logic             row_strobe_n,
   output logic             column_strobe_n,
   output logic             write_select_n,
   output logic      [1:0]  bank_select,
   output logic      [12:0] address,
   output logic             lower_byte_mask,
   output logic             upper_byte_mask,
   output logic             lower_byte_strobe_in,
   output logic             upper_byte_strobe_in,
   output logic      [15:0] data_lines_in,
   input  wire logic        lower_byte_strobe_out,
   input  wire logic        lower_byte_strobe_oe,
   input  wire logic        upper_byte_strobe_out,
   input  wire logic        upper_byte_strobe_oe,
   input  wire logic [15:0] data_lines_out,
   input  wire logic        data_lines_oe
);
   logic        drv = 1'b0;
   logic        dqs = 1'b0;
   logic [15:0] dq = 16'h0000;
   logic        ls_last = 1'b0;
   logic        us_last = 1'b0;
   logic [15:0] dq_last = 16'h0000;
   logic        rd_prev = 1'b0;
   logic [15:0] rd_q [$];
   // Undriven pins invert their last value
   assign lower_byte_strobe_in = lower_byte_strobe_oe ? lower_byte_strobe_out : drv ? dqs : ~ls_last;
   assign upper_byte_strobe_in = upper_byte_strobe_oe ? upper_byte_strobe_out : drv ? dqs : ~us_last;
   assign data_lines_in = data_lines_oe ? data_lines_out : drv ? dq : ~dq_last;
   initial begin
      {chip_select_n, row_strobe_n, column_strobe_n, write_select_n} = 4'hF;
      {bank_select, address, lower_byte_mask, upper_byte_mask} = 17'h00000;
      system_clock = 1'b0;
      #13;
      forever #80 system_clock = ~system_clock;
   end
   always @(posedge clk) begin
      {ls_last, us_last, dq_last} <= {lower_byte_strobe_in, upper_byte_strobe_in, data_lines_in};
      rd_prev <= lower_byte_strobe_out;
      // One word per driven strobe edge
      if (data_lines_oe && lower_byte_strobe_out != rd_prev) rd_q.push_back(data_lines_out);
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Pins held fall to fall
   task automatic cmd(input logic [3:0] code, input logic [1:0] bank, input logic [12:0] addr);
      @(negedge system_clock);
      @(posedge clk);
      {chip_select_n, row_strobe_n, column_strobe_n, write_select_n} <= code;
      bank_select <= bank;
      address <= addr;
      @(negedge system_clock);
      @(posedge clk);
      {chip_select_n, row_strobe_n, column_strobe_n, write_select_n} <= 4'h7;
   endtask
   task automatic write_burst(input logic [1:0] bank, input logic [8:0] col,
         input logic [63:0] w, input logic [3:0] lm, input logic [3:0] um);
      int k;
      @(posedge clk);
      drv <= 1'b1;
      dqs <= 1'b0;
      cmd(4'h4, bank, {4'h0, col});
      for (k = 0; k < 4; k++) begin
         @(posedge clk);
         dq <= w[16*k +: 16];
         lower_byte_mask <= lm[k];
         upper_byte_mask <= um[k];
         // Four clocks of set-up and hold
         repeat (4) @(posedge clk);
         dqs <= ~dqs;
         repeat (3) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      drv <= 1'b0;
   endtask
endmodule

// *** testbench/tb_top.sv ***
// Bench for the column and data pin block
`timescale 1ns/100ps
module tb_top;
   typedef struct packed {
      logic [3:0] code;
      logic [1:0] bank;
      logic       all;
      logic [3:0] open;
   } cmd_row_s;
   logic        clk, rst, ce, system_clock, chip_select_n, row_strobe_n, column_strobe_n;
   logic        write_select_n, lower_byte_mask, upper_byte_mask;
   logic        lower_byte_strobe_in, lower_byte_strobe_out, lower_byte_strobe_oe;
   logic        upper_byte_strobe_in, upper_byte_strobe_out, upper_byte_strobe_oe;
   logic        data_lines_oe, read_active, write_active, saw_write;
   logic [1:0]  bank_select;
   logic [12:0] address;
   logic [15:0] data_lines_in, data_lines_out;
   logic [3:0]  bank_open;
   logic [15:0] exp_mem [0:3];
   cmd_row_s    rows [0:9];
   int          fails = 0, checks = 0, cycles = 0;
   ddr_column_data_pins u_ddr_column_data_pins (.clk(clk), .rst(rst), .ce(ce),
      .system_clock(system_clock), .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
      .column_strobe_n(column_strobe_n), .write_select_n(write_select_n),
      .bank_select(bank_select), .address(address), .lower_byte_strobe_in(lower_byte_strobe_in),
      .lower_byte_strobe_out(lower_byte_strobe_out), .lower_byte_strobe_oe(lower_byte_strobe_oe),
      .upper_byte_strobe_in(upper_byte_strobe_in), .upper_byte_strobe_out(upper_byte_strobe_out),
      .upper_byte_strobe_oe(upper_byte_strobe_oe), .lower_byte_mask(lower_byte_mask),
      .upper_byte_mask(upper_byte_mask), .data_lines_in(data_lines_in),
      .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .bank_open(bank_open),
      .read_active(read_active), .write_active(write_active));
   ddr_ctrl_model u_ddr_ctrl_model (.clk(clk), .system_clock(system_clock),
      .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
      .column_strobe_n(column_strobe_n), .write_select_n(write_select_n),
      .bank_select(bank_select), .address(address), .lower_byte_mask(lower_byte_mask),
      .upper_byte_mask(upper_byte_mask), .lower_byte_strobe_in(lower_byte_strobe_in),
      .upper_byte_strobe_in(upper_byte_strobe_in), .data_lines_in(data_lines_in),
      .lower_byte_strobe_out(lower_byte_strobe_out), .lower_byte_strobe_oe(lower_byte_strobe_oe),
      .upper_byte_strobe_out(upper_byte_strobe_out), .upper_byte_strobe_oe(upper_byte_strobe_oe),
      .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         fails++;
         give_verdict();
      end
   end
   always @(negedge clk) if (write_active === 1'b1) saw_write = 1'b1;
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Model of wrap order and per-beat masks
   task automatic do_write(input logic [1:0] bank, input logic [8:0] col, input logic [63:0] w,
         input logic [3:0] lm, input logic [3:0] um);
      int k;
      logic [1:0] idx;
      for (k = 0; k < 4; k++) begin
         idx = col[1:0] + 2'(k);
         if (!lm[k]) exp_mem[idx][7:0] = w[16*k +: 8];
         if (!um[k]) exp_mem[idx][15:8] = w[16*k+8 +: 8];
      end
      saw_write = 1'b0;
      u_ddr_ctrl_model.write_burst(bank, col, w, lm, um);
      repeat (4) @(negedge clk);
      check(16'(saw_write), 16'h0001);
      check(16'(write_active), 16'h0000);
   endtask
   task automatic do_read(input logic [1:0] bank, input logic [8:0] col, input int words);
      int n;
      u_ddr_ctrl_model.rd_q.delete();
      u_ddr_ctrl_model.cmd(4'h5, bank, {4'h0, col});
      for (n = 0; n < 100 && data_lines_oe !== 1'b1; n++) @(negedge clk);
      for (n = 0; n < 100 && data_lines_oe !== 1'b0; n++) @(negedge clk);
      check(16'(u_ddr_ctrl_model.rd_q.size()), 16'(words));
      for (n = 0; n < words; n++) begin
         check(u_ddr_ctrl_model.rd_q[n], exp_mem[col[1:0] + 2'(n)]);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int i;
      rows = '{'{4'hB, 2'h0, 1'b0, 4'h0}, '{4'h3, 2'h0, 1'b0, 4'h1}, '{4'h3, 2'h2, 1'b0, 4'h5},
               '{4'h0, 2'h1, 1'b0, 4'h5}, '{4'h1, 2'h3, 1'b0, 4'h5}, '{4'h2, 2'h0, 1'b0, 4'h4},
               '{4'h3, 2'h1, 1'b0, 4'h6}, '{4'h3, 2'h3, 1'b0, 4'hE}, '{4'h2, 2'h2, 1'b1, 4'h0},
               '{4'h3, 2'h1, 1'b0, 4'h2}};
      rst = 1'b1;
      ce = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check(16'(bank_open), 16'h0000);
      check({11'h000, read_active, write_active, data_lines_oe, lower_byte_strobe_oe,
             upper_byte_strobe_oe}, 16'h0000);
      for (i = 0; i < 10; i++) begin
         u_ddr_ctrl_model.cmd(rows[i].code, rows[i].bank, {2'h0, rows[i].all, 10'h000});
         repeat (4) @(negedge clk);
         check(16'(bank_open), 16'(rows[i].open));
      end
      // Second write wraps over the first
      do_write(2'h1, 9'h004, 64'h4444_3333_2222_1111, 4'h0, 4'h0);
      do_write(2'h1, 9'h006, 64'hDDD4_CCC3_BBB2_AAA1, 4'h1, 4'h4);
      do_read(2'h1, 9'h004, 4);
      do_read(2'h1, 9'h007, 4);
      do_read(2'h0, 9'h004, 0);
      u_ddr_ctrl_model.cmd(4'h4, 2'h2, 13'h0004);
      repeat (8) @(negedge clk);
      check(16'(write_active), 16'h0000);
      give_verdict();
   end
endmodule
